// >>> hdl/adcr_pkg.sv
// Shared constants and types for the converter status and calibration register bank
package adcr_pkg;

  // Control word field positions
  localparam int unsigned CTL_POWER_HI = 9;
  localparam int unsigned CTL_POWER_LO = 8;
  localparam int unsigned CTL_TARGET_HI = 7;
  localparam int unsigned CTL_TARGET_LO = 6;
  localparam int unsigned CTL_MODE = 5;
  localparam int unsigned CTL_CONV_START = 4;
  localparam int unsigned CTL_CAL_TYPE = 3;
  localparam int unsigned CTL_SCOPE_HI = 2;
  localparam int unsigned CTL_SCOPE_LO = 1;
  localparam int unsigned CTL_CAL_START = 0;

  // Status word field positions
  localparam int unsigned STS_ZERO_TOP = 15;
  localparam int unsigned STS_BUSY = 14;
  localparam int unsigned STS_ZERO_HI = 13;
  localparam int unsigned STS_ZERO_LO = 10;
  localparam int unsigned STS_POWER_HI = 9;
  localparam int unsigned STS_POWER_LO = 8;
  localparam int unsigned STS_IDENT_HI = 7;
  localparam int unsigned STS_IDENT_LO = 6;
  localparam int unsigned STS_MODE = 5;
  localparam int unsigned STS_DONT_CARE = 4;
  localparam int unsigned STS_CAL_TYPE = 3;
  localparam int unsigned STS_SCOPE_HI = 2;
  localparam int unsigned STS_SCOPE_LO = 1;
  localparam int unsigned STS_CAL_RUN = 0;

  // Calibration bank geometry
  localparam int unsigned CAL_COUNT = 10;
  localparam int unsigned CAL_DATA_W = 14;
  localparam logic [3:0] CAL_IDX_GAIN = 4'h0;
  localparam logic [3:0] CAL_IDX_OFFSET = 4'h1;
  localparam logic [3:0] CAL_IDX_ARRAY_LAST = 4'h9;

  // Values after reset
  localparam logic [13:0] CAL_OFFSET_RST = 14'h2000;
  localparam logic [13:0] CAL_OTHER_RST = 14'h0000;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [1:0] STS_IDENT_VAL = 2'h3;

  // Read target selection
  typedef enum logic [1:0] {
    ADCR_TGT_RESULT0 = 2'b00,
    ADCR_TGT_RESULT1 = 2'b01,
    ADCR_TGT_CAL = 2'b10,
    ADCR_TGT_STATUS = 2'b11
  } adcr_target_e;

  // Calibration scope selection
  typedef enum logic [1:0] {
    ADCR_SCOPE_ALL = 2'b00,
    ADCR_SCOPE_GAIN_OFFSET = 2'b01,
    ADCR_SCOPE_OFFSET = 2'b10,
    ADCR_SCOPE_GAIN = 2'b11
  } adcr_scope_e;

endpackage : adcr_pkg

// >>> hdl/adcr_ptr_if.sv
// Interface between the register bank and its calibration pointer unit
`timescale 1ns/1ps
`default_nettype none
interface adcr_ptr_if;
  import adcr_pkg::*;
  adcr_scope_e scope;
  logic restart;
  logic step;
  logic [3:0] idx;

  modport bank (output scope, output restart, output step, input idx);
  modport ptr (input scope, input restart, input step, output idx);
endinterface : adcr_ptr_if
`default_nettype wire

// >>> hdl/adcr_cal_ptr.sv
// Auto-incrementing calibration register pointer
`timescale 1ns/1ps
`default_nettype none
module adcr_cal_ptr
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Bank side
  adcr_ptr_if.ptr p
);

  logic [3:0] idx_r;
  logic [3:0] idx_nxt;

  // First register of a sequence: gain, except offset alone
  function automatic logic [3:0] first_of(input adcr_scope_e s);
    first_of = (s == ADCR_SCOPE_OFFSET) ? CAL_IDX_OFFSET : CAL_IDX_GAIN;
  endfunction : first_of

  // Last register of a sequence
  function automatic logic [3:0] last_of(input adcr_scope_e s);
    case (s)
      ADCR_SCOPE_ALL: last_of = CAL_IDX_ARRAY_LAST;
      ADCR_SCOPE_GAIN_OFFSET: last_of = CAL_IDX_OFFSET;
      ADCR_SCOPE_OFFSET: last_of = CAL_IDX_OFFSET;
      default: last_of = CAL_IDX_GAIN;
    endcase
  endfunction : last_of

  // Next pointer: restart wins over step so an abandoned sequence starts clean
  always_comb begin
    idx_nxt = idx_r;
    if (p.restart) begin
      idx_nxt = first_of(p.scope);
    end else if (p.step) begin
      if (idx_r == last_of(p.scope)) begin
        idx_nxt = first_of(p.scope);
      end else begin
        idx_nxt = idx_r + 4'h1;
      end
    end
  end

  // Pointer register; reset scope is all, so gain is addressed
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      idx_r <= CAL_IDX_GAIN;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  assign p.idx = idx_r;

endmodule : adcr_cal_ptr
`default_nettype wire

// >>> hdl/adcr_regs.sv
// Status word and calibration register bank of a serial converter
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Status bit 15 always reads zero.
// - Status bit 14 is high while a conversion or calibration runs.
// - Status bits 13 to 10 always read zero.
// - Status bits 9 and 8 echo the two power setting bits.
// - Status bits 7 and 6 always read one, marking the status word.
// - Status bit 5 shows interface mode and clears after a read cycle, unless a control write comes in the same cycle.
// - Status bit 3 shows the calibration type: self zero, system one.
// - Status bit 0 is high while a calibration is running.
// - Status bits 2 and 1 show the calibration scope selection.
// - Ten calibration registers exist, all host writable and readable.
// - The calibration engine updates the registers itself when calibrating.
// - Scope 00 all, 01 gain and offset, 10 offset, 11 gain.
// - Pointer returns to sequence start on control write or sequence end.
// - After reset pointer addresses gain, or offset when scope is 10.
// - Pointer steps by one after each access when scope spans several.
// - Host may abandon a sequence; next control write resets the pointer.
// - Calibration reads return two leading zero bits.
// - Offset register is two zeros and fourteen data bits, nominal 0x2000.
// - Read target 11 makes reads return the status word.
// - With start bit zero the scope field addresses registers.
// - Status fields clear at power-up.
module adcr_regs
  import adcr_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Control register write
  input wire logic i_ctrl_wr,
  input wire logic [15:0] i_ctrl_word,
  // Calibration register write from host
  input wire logic i_cal_wr,
  input wire logic [15:0] i_cal_wdata,
  // Read cycle end and read data
  input wire logic i_rd_done,
  output logic [15:0] o_rdata,
  // Conversion engine
  input wire logic i_conv_busy,
  input wire logic [13:0] i_conv_result,
  output logic o_conv_start,
  // Calibration engine
  input wire logic i_cal_done,
  input wire logic i_cal_upd_we,
  input wire logic [3:0] i_cal_upd_idx,
  input wire logic [13:0] i_cal_upd_data,
  output logic o_cal_start,
  output logic o_cal_type,
  output logic [1:0] o_cal_scope,
  // Trim values and settings towards the analog side
  output logic [13:0] o_gain_trim,
  output logic [13:0] o_offset_trim,
  output logic [1:0] o_power_setting,
  output logic o_mode_two_wire
);

  // Stored control fields
  logic [1:0] power_setting_r;
  adcr_target_e read_target_r;
  logic mode_two_wire_r;
  logic cal_type_select_r;
  adcr_scope_e cal_scope_r;
  logic cal_running_r;
  logic conv_start_r;
  logic cal_start_r;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [15:0] status_word;

  // Calibration coefficient storage
  logic [CAL_DATA_W-1:0] cal_r [CAL_COUNT];

  // Decoded control word fields
  logic ctl_start_flag;
  logic ctl_conv_start;
  adcr_scope_e ctl_scope;
  adcr_target_e ctl_target;

  // Pointer unit connection
  adcr_ptr_if ptr_bus ();
  logic cal_access;

  // Per-entry write enables of the calibration bank
  logic [CAL_COUNT-1:0] eng_we;
  logic [CAL_COUNT-1:0] host_we;

  assign ctl_start_flag = i_ctrl_word[CTL_CAL_START];
  assign ctl_conv_start = i_ctrl_word[CTL_CONV_START];
  assign ctl_scope = adcr_scope_e'(i_ctrl_word[CTL_SCOPE_HI:CTL_SCOPE_LO]);
  assign ctl_target = adcr_target_e'(i_ctrl_word[CTL_TARGET_HI:CTL_TARGET_LO]);

  // Power setting bits follow each control write
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      power_setting_r <= CTL_RST[CTL_POWER_HI:CTL_POWER_LO];
    end else if (i_ctrl_wr) begin
      power_setting_r <= i_ctrl_word[CTL_POWER_HI:CTL_POWER_LO];
    end
  end

  // Read target; it only moves on a control write, so reads never switch words mid-sequence
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      read_target_r <= adcr_target_e'(CTL_RST[CTL_TARGET_HI:CTL_TARGET_LO]);
    end else if (i_ctrl_wr) begin
      read_target_r <= ctl_target;
    end
  end

  // Calibration type: self or system
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cal_type_select_r <= CTL_RST[CTL_CAL_TYPE];
    end else if (i_ctrl_wr) begin
      cal_type_select_r <= i_ctrl_word[CTL_CAL_TYPE];
    end
  end

  // Scope field; with the start bit clear it acts as the register address
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cal_scope_r <= adcr_scope_e'(CTL_RST[CTL_SCOPE_HI:CTL_SCOPE_LO]);
    end else if (i_ctrl_wr) begin
      cal_scope_r <= ctl_scope;
    end
  end

  // Mode bit: a write in the same cycle as a read end wins, so
  // a host in two-wire mode that rewrites it each write keeps it
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mode_two_wire_r <= CTL_RST[CTL_MODE];
    end else if (i_ctrl_wr) begin
      mode_two_wire_r <= i_ctrl_word[CTL_MODE];
    end else if (i_rd_done) begin
      mode_two_wire_r <= 1'b0;
    end
  end

  // Calibration running flag: a start wins over a done in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cal_running_r <= 1'b0;
    end else if (i_ctrl_wr && ctl_start_flag) begin
      cal_running_r <= 1'b1;
    end else if (i_cal_done) begin
      cal_running_r <= 1'b0;
    end
  end

  // One-cycle conversion start pulse towards the conversion engine
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= i_ctrl_wr && ctl_conv_start;
    end
  end

  // One-cycle calibration start pulse; the engine sees it one clock after the write
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cal_start_r <= 1'b0;
    end else begin
      cal_start_r <= i_ctrl_wr && ctl_start_flag;
    end
  end

  // Pointer control; every control write restarts, including start-flag writes,
  // so an abandoned sequence can never leave the pointer mid-way
  assign cal_access = (i_cal_wr || (i_rd_done && (read_target_r == ADCR_TGT_CAL))) && !cal_running_r;
  assign ptr_bus.restart = i_ctrl_wr;
  assign ptr_bus.step = cal_access && !i_ctrl_wr;
  assign ptr_bus.scope = i_ctrl_wr ? ctl_scope : cal_scope_r;

  adcr_cal_ptr u_ptr (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .p(ptr_bus.ptr)
  );

  // One-hot entry select, shared by the engine and host write paths
  function automatic logic [CAL_COUNT-1:0] entry_sel(input logic [3:0] idx);
    entry_sel = '0;
    for (int unsigned k = 0; k < CAL_COUNT; k++) begin
      if (idx == 4'(k)) begin
        entry_sel[k] = 1'b1;
      end
    end
  endfunction : entry_sel

  // Write enables; host writes are refused while a calibration runs
  assign eng_we = i_cal_upd_we ? entry_sel(i_cal_upd_idx) : '0;
  assign host_we = (i_cal_wr && !cal_running_r) ? entry_sel(ptr_bus.idx) : '0;

  // Calibration registers: the engine's update wins over a host write to
  // the same entry, since host access is only for manual adjustment
  generate
    for (genvar gi = 0; gi < CAL_COUNT; gi++) begin : g_cal
      localparam logic [3:0] IDX = 4'(gi);
      localparam logic [13:0] RST = (IDX == CAL_IDX_OFFSET) ? CAL_OFFSET_RST : CAL_OTHER_RST;
      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          cal_r[gi] <= RST;
        end else if (eng_we[gi]) begin
          cal_r[gi] <= i_cal_upd_data;
        end else if (host_we[gi]) begin
          cal_r[gi] <= i_cal_wdata[CAL_DATA_W-1:0];
        end
      end
    end
  endgenerate

  // Status word assembly
  always_comb begin
    status_word = 16'h0000;
    status_word[STS_ZERO_TOP] = 1'b0;
    status_word[STS_BUSY] = i_conv_busy | cal_running_r;
    status_word[STS_ZERO_HI:STS_ZERO_LO] = 4'h0;
    status_word[STS_POWER_HI:STS_POWER_LO] = power_setting_r;
    status_word[STS_IDENT_HI:STS_IDENT_LO] = STS_IDENT_VAL;
    status_word[STS_MODE] = mode_two_wire_r;
    status_word[STS_DONT_CARE] = 1'b0;
    status_word[STS_CAL_TYPE] = cal_type_select_r;
    status_word[STS_SCOPE_HI:STS_SCOPE_LO] = cal_scope_r;
    status_word[STS_CAL_RUN] = cal_running_r;
  end

  // Read data selection by read target
  always_comb begin
    case (read_target_r)
      ADCR_TGT_STATUS: rdata_nxt = status_word;
      ADCR_TGT_CAL: rdata_nxt = {2'b00, cal_r[ptr_bus.idx]};
      default: rdata_nxt = {2'b00, i_conv_result};
    endcase
  end

  // Registered read data, refreshed every cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs
  assign o_rdata = rdata_r;
  assign o_conv_start = conv_start_r;
  assign o_cal_start = cal_start_r;
  assign o_cal_type = cal_type_select_r;
  assign o_cal_scope = cal_scope_r;
  assign o_gain_trim = cal_r[CAL_IDX_GAIN];
  assign o_offset_trim = cal_r[CAL_IDX_OFFSET];
  assign o_power_setting = power_setting_r;
  assign o_mode_two_wire = mode_two_wire_r;

endmodule : adcr_regs
`default_nettype wire

// >>> test/adcr_regs_props.sv
// Concurrent checks on the ports of the converter status and calibration bank
`timescale 1ns/1ps
`default_nettype none
module adcr_regs_chk (
  // Clock, reset and inputs
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ctrl_wr,
  input wire logic [15:0] i_ctrl_word,
  input wire logic i_rd_done,
  input wire logic i_conv_busy,
  input wire logic i_cal_upd_we,
  input wire logic [3:0] i_cal_upd_idx,
  input wire logic [13:0] i_cal_upd_data,
  // Outputs watched
  input wire logic [15:0] o_rdata,
  input wire logic o_conv_start,
  input wire logic o_cal_start,
  input wire logic o_cal_type,
  input wire logic [1:0] o_cal_scope,
  input wire logic [13:0] o_gain_trim,
  input wire logic [1:0] o_power_setting,
  input wire logic o_mode_two_wire
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic [1:0] tgt_r;
  logic [1:0] tgt_q_r;
  logic sts_view;
  logic cal_view;
  // Shadow of the read target; o_rdata lags the stored target by one cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tgt_r <= 2'h0;
      tgt_q_r <= 2'h0;
    end else begin
      tgt_r <= i_ctrl_wr ? i_ctrl_word[7:6] : tgt_r;
      tgt_q_r <= tgt_r;
    end
  end
  assign sts_view = (tgt_r == 2'h3) && (tgt_q_r == 2'h3);
  assign cal_view = (tgt_r == 2'h2) && (tgt_q_r == 2'h2);

  status_fixed_bits_a: assert property (sts_view |-> !o_rdata[15] && o_rdata[13:10] == 4'h0 && o_rdata[7:6] == 2'h3)
    else $error("status fixed bits wrong");
  busy_flag_a: assert property (sts_view |-> o_rdata[14] == ($past(i_conv_busy) || o_rdata[0]))
    else $error("status busy bit wrong");
  power_echo_a: assert property (i_ctrl_wr |=> o_power_setting == $past(i_ctrl_word[9:8]))
    else $error("power setting not stored");
  mode_clear_a: assert property (i_rd_done && !i_ctrl_wr |=> !o_mode_two_wire)
    else $error("mode bit kept after read");
  cal_running_a: assert property (o_cal_start && sts_view |=> o_rdata[0] && o_rdata[14])
    else $error("cal running not shown");
  cal_start_a: assert property (i_ctrl_wr && i_ctrl_word[0] |=> o_cal_start)
    else $error("cal start pulse missing");
  cal_type_echo_a: assert property (i_ctrl_wr |=> o_cal_type == $past(i_ctrl_word[3]))
    else $error("cal type not stored");
  scope_echo_a: assert property (i_ctrl_wr |=> o_cal_scope == $past(i_ctrl_word[2:1]))
    else $error("scope not stored");
  gain_update_a: assert property (i_cal_upd_we && i_cal_upd_idx == 4'h0 |=> o_gain_trim == $past(i_cal_upd_data))
    else $error("engine gain update lost");
  cal_lead_zero_a: assert property (cal_view |-> o_rdata[15:14] == 2'h0)
    else $error("cal read leading bits set");
  status_select_a: assert property (i_ctrl_wr && i_ctrl_word[7:6] == 2'h3 |=> ##1 o_rdata[7:6] == 2'h3)
    else $error("status word not selected");
  conv_quiet_a: assert property (!(i_ctrl_wr && i_ctrl_word[4]) |=> !o_conv_start)
    else $error("spurious conversion start");

  // Main scenarios reached
  cover property (sts_view && o_rdata[14]);
  cover property (cal_view && i_rd_done);
  cover property (i_cal_upd_we && i_cal_upd_idx == 4'h1);
endmodule : adcr_regs_chk
bind adcr_regs adcr_regs_chk chk_u (.i_mclk, .i_srst, .i_ctrl_wr, .i_ctrl_word, .i_rd_done, .i_conv_busy,
  .i_cal_upd_we, .i_cal_upd_idx, .i_cal_upd_data, .o_rdata, .o_conv_start, .o_cal_start, .o_cal_type, .o_cal_scope,
  .o_gain_trim, .o_power_setting, .o_mode_two_wire);
`default_nettype wire

// >>> test/adcr_cal_engine.sv
// Behavioural calibration engine answering the bank's start pulses
`timescale 1ns/1ps
`default_nettype none
module adcr_cal_engine #(
  parameter logic [13:0] GAIN_VAL = 14'h1a5c,
  parameter logic [13:0] OFFSET_VAL = 14'h2011
) (
  // Clock, reset and answer speed
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_slow,
  // Bank side
  input wire logic i_start,
  output logic o_upd_we,
  output logic [3:0] o_upd_idx,
  output logic [13:0] o_upd_data,
  output logic o_done
);
  logic [3:0] cnt_r;
  // Gain then offset are rewritten at the end of a run, so slow runs show busy longer
  always_ff @(posedge i_mclk) begin
    o_upd_we <= (cnt_r == 4'h3) || (cnt_r == 4'h2);
    o_upd_idx <= (cnt_r == 4'h3) ? 4'h0 : 4'h1;
    o_upd_data <= (cnt_r == 4'h3) ? GAIN_VAL : OFFSET_VAL;
    o_done <= (cnt_r == 4'h1);
    if (i_srst) begin
      cnt_r <= 4'h0;
    end else if (i_start) begin
      cnt_r <= i_slow ? 4'hc : 4'h4;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : adcr_cal_engine
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the status and calibration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [13:0] GAIN_VAL = 14'h1a5c;
  localparam logic [13:0] OFFSET_VAL = 14'h2011;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ctrl_wr = 1'b0;
  logic i_cal_wr = 1'b0;
  logic i_rd_done = 1'b0;
  logic i_conv_busy = 1'b0;
  logic slow = 1'b0;
  logic [15:0] i_ctrl_word = 16'h0000;
  logic [15:0] i_cal_wdata = 16'h0000;
  logic [13:0] i_conv_result = 14'h2abc;
  logic [15:0] o_rdata;
  logic o_conv_start, o_cal_start, o_cal_type, o_mode_two_wire, i_cal_done, i_cal_upd_we;
  logic [1:0] o_cal_scope, o_power_setting;
  logic [3:0] i_cal_upd_idx;
  logic [13:0] i_cal_upd_data, o_gain_trim, o_offset_trim;
  int n_fail = 0;
  int check_count = 0;

  adcr_regs dut_u (.i_mclk, .i_srst, .i_ctrl_wr, .i_ctrl_word, .i_cal_wr, .i_cal_wdata, .i_rd_done, .o_rdata,
    .i_conv_busy, .i_conv_result, .o_conv_start, .i_cal_done, .i_cal_upd_we, .i_cal_upd_idx, .i_cal_upd_data,
    .o_cal_start, .o_cal_type, .o_cal_scope, .o_gain_trim, .o_offset_trim, .o_power_setting, .o_mode_two_wire);
  adcr_cal_engine #(.GAIN_VAL(GAIN_VAL), .OFFSET_VAL(OFFSET_VAL)) eng_u (.i_mclk, .i_srst, .i_slow(slow),
    .i_start(o_cal_start), .o_upd_we(i_cal_upd_we), .o_upd_idx(i_cal_upd_idx), .o_upd_data(i_cal_upd_data),
    .o_done(i_cal_done));

  // Clock and hang guard
  initial forever #25 i_mclk = ~i_mclk;
  initial begin
    #(50 * 4000);
    n_fail++;
    final_report();
  end

  task automatic final_report();
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle request: 0 control write, 1 cal write, 2 read cycle end
  task automatic pulse(input int sel, input logic [15:0] val);
    @(negedge i_mclk);
    i_ctrl_word = val;
    i_cal_wdata = val;
    i_ctrl_wr = (sel == 0);
    i_cal_wr = (sel == 1);
    i_rd_done = (sel == 2);
    @(negedge i_mclk);
    i_ctrl_wr = 1'b0;
    i_cal_wr = 1'b0;
    i_rd_done = 1'b0;
  endtask : pulse

  // Read word one cycle after the state change
  task automatic look(input logic [15:0] exp);
    @(negedge i_mclk);
    chk(o_rdata, exp);
  endtask : look

  // Host pattern; top two bits set to prove they are dropped
  function automatic logic [15:0] cv(input int i);
    return 16'hc000 | (16'(i) * 16'h0527);
  endfunction : cv

  task automatic t_reset();
    @(negedge i_mclk);
    chk(o_rdata, {2'b00, i_conv_result});
    chk({2'b00, o_offset_trim}, 16'h2000);
    chk({2'b00, o_gain_trim}, 16'h0000);
    // A host write before any control write lands in gain
    pulse(1, 16'h0123);
    chk({2'b00, o_gain_trim}, 16'h0123);
    chk({2'b00, o_offset_trim}, 16'h2000);
    pulse(0, 16'h00c0);
    look(16'h00c0);
  endtask : t_reset

  task automatic t_status();
    pulse(0, 16'h03fe);
    look(16'h03ee);
    chk({15'h0000, o_cal_type}, 16'h0001);
    pulse(2, 16'h0000);
    look(16'h03ce);
    i_conv_busy = 1'b1;
    look(16'h43ce);
    i_conv_busy = 1'b0;
  endtask : t_status

  task automatic t_full();
    pulse(0, 16'h0080);
    for (int i = 0; i < 10; i++) pulse(1, cv(i));
    // Two-wire mode set with the reads; the bit clears at the first read end and does not gate the sequence
    pulse(0, 16'h00a0);
    for (int i = 0; i < 11; i++) begin
      look(cv(i % 10) & 16'h3fff);
      pulse(2, 16'h0000);
    end
    chk({2'b00, o_gain_trim}, cv(0) & 16'h3fff);
    chk({2'b00, o_offset_trim}, cv(1) & 16'h3fff);
  endtask : t_full

  task automatic t_scopes();
    logic ofs;
    for (int s = 1; s < 4; s++) begin
      pulse(0, 16'h0080 | 16'(s * 2));
      for (int k = 0; k < 3; k++) begin
        ofs = (s == 2) || (s == 1 && k == 1);
        look(cv(ofs ? 1 : 0) & 16'h3fff);
        pulse(2, 16'h0000);
      end
    end
  endtask : t_scopes

  task automatic t_abort();
    pulse(0, 16'h0080);
    repeat (3) pulse(2, 16'h0000);
    pulse(0, 16'h0080);
    look(cv(0) & 16'h3fff);
  endtask : t_abort

  task automatic t_calrun();
    for (int s = 1; s >= 0; s--) begin
      slow = s[0];
      pulse(0, 16'h00c0);
      pulse(0, 16'h00c1);
      look(16'h40c1);
      for (int k = 0; k < 30 && o_rdata[0] !== 1'b0; k++) @(negedge i_mclk);
      chk(o_rdata, 16'h00c0);
      chk({2'b00, o_gain_trim}, {2'b00, GAIN_VAL});
      chk({2'b00, o_offset_trim}, {2'b00, OFFSET_VAL});
    end
  endtask : t_calrun

  initial begin
    repeat (20) @(negedge i_mclk);
    i_srst = 1'b0;
    t_reset();
    t_status();
    t_full();
    t_scopes();
    t_abort();
    t_calrun();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
